// File: hdl/hpbsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpbsc_cfg.svh"

module hpbsc_top
(
  // Clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RST_N,
  // Configuration port
  input  wire logic [7:0]            CFG_ADDR,
  input  wire logic [7:0]            CFG_WDATA,
  input  wire logic                  CFG_WR,
  input  wire logic                  CFG_RD,
  output logic      [7:0]            CFG_RDATA,
  output logic                       CFG_RVALID,
  // Static transceiver controls
  output hpbsc_pkg::hpbsc_boost_t    UPSTREAM_BOOST_LEVEL,
  output hpbsc_pkg::hpbsc_boost_t    DOWN1_BOOST_LEVEL,
  output hpbsc_pkg::hpbsc_boost_t    DOWN2_BOOST_LEVEL,
  output hpbsc_pkg::hpbsc_ports_t    LINE_SWAP_BITS,
  // Core side of the data lines
  input  wire hpbsc_pkg::hpbsc_ports_t CORE_POS_OUT,
  input  wire hpbsc_pkg::hpbsc_ports_t CORE_NEG_OUT,
  input  wire hpbsc_pkg::hpbsc_ports_t CORE_LINE_OE,
  output hpbsc_pkg::hpbsc_ports_t    CORE_POS_IN,
  output hpbsc_pkg::hpbsc_ports_t    CORE_NEG_IN,
  // Pin side of the data lines
  input  wire hpbsc_pkg::hpbsc_ports_t POSITIVE_LINE_PIN_I,
  input  wire hpbsc_pkg::hpbsc_ports_t NEGATIVE_LINE_PIN_I,
  output hpbsc_pkg::hpbsc_ports_t    POSITIVE_LINE_PIN_O,
  output hpbsc_pkg::hpbsc_ports_t    NEGATIVE_LINE_PIN_O,
  output hpbsc_pkg::hpbsc_ports_t    POSITIVE_LINE_PIN_OE,
  output hpbsc_pkg::hpbsc_ports_t    NEGATIVE_LINE_PIN_OE
);

  // ****************************************
  // Helpers
  // ****************************************
  // Per-bit line crossing, shared by both directions
  function automatic hpbsc_pkg::hpbsc_ports_t pick_line
  (
    input hpbsc_pkg::hpbsc_ports_t swap,
    input hpbsc_pkg::hpbsc_ports_t straight,
    input hpbsc_pkg::hpbsc_ports_t crossed
  );
    pick_line = (straight & ~swap) | (crossed & swap);
  endfunction

  logic wr_up;
  logic wr_dn;
  logic wr_swap;

  // Address decode
  assign wr_up   = CFG_WR && (CFG_ADDR == `HPBSC_UP_BOOST_ADDR);
  assign wr_dn   = CFG_WR && (CFG_ADDR == `HPBSC_DN_BOOST_ADDR);
  assign wr_swap = CFG_WR && (CFG_ADDR == `HPBSC_SWAP_ADDR);

  // ****************************************
  // Configuration registers
  // ****************************************
  // Upstream boost; upper bits are not stored so they read as zero
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      UPSTREAM_BOOST_LEVEL <= `HPBSC_BOOST_RST;
    else if (wr_up)
      UPSTREAM_BOOST_LEVEL <= CFG_WDATA[`HPBSC_UP_LVL_LSB +: 2];
  end

  // Downstream boost pair
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DOWN1_BOOST_LEVEL <= `HPBSC_BOOST_RST;
      DOWN2_BOOST_LEVEL <= `HPBSC_BOOST_RST;
    end
    else if (wr_dn)
    begin
      DOWN2_BOOST_LEVEL <= CFG_WDATA[`HPBSC_DN2_LVL_LSB +: 2];
      DOWN1_BOOST_LEVEL <= CFG_WDATA[`HPBSC_DN1_LVL_LSB +: 2];
    end
  end

  // Swap flags; reserved bits 7:3 are dropped
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      LINE_SWAP_BITS <= `HPBSC_SWAP_RST;
    else if (wr_swap)
    begin
      LINE_SWAP_BITS[`HPBSC_SWAP_DN2_BIT] <= CFG_WDATA[`HPBSC_SWAP_DN2_BIT];
      LINE_SWAP_BITS[`HPBSC_SWAP_DN1_BIT] <= CFG_WDATA[`HPBSC_SWAP_DN1_BIT];
      LINE_SWAP_BITS[`HPBSC_SWAP_UP_BIT]  <= CFG_WDATA[`HPBSC_SWAP_UP_BIT];
    end
  end

  // Read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CFG_RDATA  <= 8'h00;
      CFG_RVALID <= 1'b0;
    end
    else
    begin
      CFG_RVALID <= CFG_RD;
      if (CFG_RD)
        unique case (CFG_ADDR)
          `HPBSC_UP_BOOST_ADDR: CFG_RDATA <= {6'h00, UPSTREAM_BOOST_LEVEL};
          `HPBSC_DN_BOOST_ADDR: CFG_RDATA <= {4'h0, DOWN2_BOOST_LEVEL,
                                              DOWN1_BOOST_LEVEL};
          `HPBSC_SWAP_ADDR:     CFG_RDATA <= {5'h00, LINE_SWAP_BITS};
          default:              CFG_RDATA <= 8'h00;
        endcase
    end
  end

  // ****************************************
  // Data line pin mapping
  // ****************************************
  // Registered so every pin comes from a flop; costs one cycle of latency
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      POSITIVE_LINE_PIN_O  <= 3'h0;
      NEGATIVE_LINE_PIN_O  <= 3'h0;
      POSITIVE_LINE_PIN_OE <= 3'h0;
      NEGATIVE_LINE_PIN_OE <= 3'h0;
    end
    else
    begin
      POSITIVE_LINE_PIN_O  <= pick_line(LINE_SWAP_BITS, CORE_POS_OUT, CORE_NEG_OUT);
      NEGATIVE_LINE_PIN_O  <= pick_line(LINE_SWAP_BITS, CORE_NEG_OUT, CORE_POS_OUT);
      // Both pins of a pair share one enable, so swapping never splits them
      POSITIVE_LINE_PIN_OE <= CORE_LINE_OE;
      NEGATIVE_LINE_PIN_OE <= CORE_LINE_OE;
    end
  end

  // Receive side mirrors the transmit crossing
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CORE_POS_IN <= 3'h0;
      CORE_NEG_IN <= 3'h0;
    end
    else
    begin
      CORE_POS_IN <= pick_line(LINE_SWAP_BITS, POSITIVE_LINE_PIN_I, NEGATIVE_LINE_PIN_I);
      CORE_NEG_IN <= pick_line(LINE_SWAP_BITS, NEGATIVE_LINE_PIN_I, POSITIVE_LINE_PIN_I);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence up_write_s;
    CFG_WR && (CFG_ADDR == `HPBSC_UP_BOOST_ADDR);
  endsequence

  sequence dn_write_s;
    CFG_WR && (CFG_ADDR == `HPBSC_DN_BOOST_ADDR);
  endsequence

  sequence swap_write_s;
    CFG_WR && (CFG_ADDR == `HPBSC_SWAP_ADDR);
  endsequence

  sequence swap_read_s;
    CFG_RD && !CFG_WR && (CFG_ADDR == `HPBSC_SWAP_ADDR);
  endsequence

  up_boost_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    up_write_s |=> UPSTREAM_BOOST_LEVEL == $past(CFG_WDATA[1:0]))
    else $error("upstream boost not loaded from bits 1:0");

  dn2_boost_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    dn_write_s |=> DOWN2_BOOST_LEVEL == $past(CFG_WDATA[3:2]))
    else $error("port 2 boost not loaded from bits 3:2");

  dn1_boost_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    dn_write_s |=> DOWN1_BOOST_LEVEL == $past(CFG_WDATA[1:0]))
    else $error("port 1 boost not loaded from bits 1:0");

  straight_map_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !LINE_SWAP_BITS[0] |=>
      POSITIVE_LINE_PIN_O[0] == $past(CORE_POS_OUT[0]) &&
      NEGATIVE_LINE_PIN_O[0] == $past(CORE_NEG_OUT[0]))
    else $error("unswapped upstream lines not straight");

  crossed_map_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    swap_write_s ##1 LINE_SWAP_BITS[2] |=>
      POSITIVE_LINE_PIN_O[2] == $past(CORE_NEG_OUT[2]) &&
      CORE_POS_IN[2] == $past(NEGATIVE_LINE_PIN_I[2]))
    else $error("swapped port 2 lines not crossed");

  swap_bits_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    swap_write_s |=> LINE_SWAP_BITS == $past(CFG_WDATA[2:0]))
    else $error("swap flags not loaded from bits 2:0");

  swap_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(CFG_WR && (CFG_ADDR == `HPBSC_SWAP_ADDR)) |=> $stable(LINE_SWAP_BITS))
    else $error("swap flags changed without a write");

  swap_readback_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    swap_read_s |=> CFG_RVALID && CFG_RDATA == {5'h00, $past(LINE_SWAP_BITS)})
    else $error("swap readback wrong or reserved bits set");

  boost_reserved_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CFG_RD && (CFG_ADDR == `HPBSC_DN_BOOST_ADDR) |=>
      CFG_RVALID &&
      CFG_RDATA == {4'h0, $past(DOWN2_BOOST_LEVEL), $past(DOWN1_BOOST_LEVEL)})
    else $error("reserved boost bits read nonzero");

endmodule // hpbsc_top

`default_nettype wire

// File: include/hpbsc_cfg.svh
`ifndef HPBSC_CFG_SVH
`define HPBSC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define HPBSC_UP_BOOST_ADDR   8'hf6
`define HPBSC_DN_BOOST_ADDR   8'hf8
`define HPBSC_SWAP_ADDR       8'hfa

// ****************************************
// Field positions and reset values
// ****************************************
`define HPBSC_UP_LVL_LSB      0
`define HPBSC_DN1_LVL_LSB     0
`define HPBSC_DN2_LVL_LSB     2
`define HPBSC_SWAP_UP_BIT     0
`define HPBSC_SWAP_DN1_BIT    1
`define HPBSC_SWAP_DN2_BIT    2
`define HPBSC_BOOST_RST       2'h0
`define HPBSC_SWAP_RST        3'h0
`define HPBSC_PORTS           3

`endif

// File: include/hpbsc_pkg.sv
`default_nettype none
package hpbsc_pkg;
  // Two-bit drive boost code: 0 none, 1 low, 2 medium, 3 high
  typedef logic [1:0] hpbsc_boost_t;
  // One bit per port: 0 upstream, 1 downstream 1, 2 downstream 2
  typedef logic [2:0] hpbsc_ports_t;
endpackage
`default_nettype wire

// File: sim/hpbsc_cfg_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Configuration host model
// ****************************************
module hpbsc_cfg_host
(
  // Clock
  input  wire logic       MCLK,
  // Register strobe port
  output var  logic [7:0] CFG_ADDR,
  output var  logic [7:0] CFG_WDATA,
  output var  logic       CFG_WR,
  output var  logic       CFG_RD
);
  // Idle bus; boost stays at zero unless a test asks for more
  initial
  begin
    CFG_ADDR  = 8'h00;
    CFG_WDATA = 8'h00;
    CFG_WR    = 1'b0;
    CFG_RD    = 1'b0;
  end

  // One-cycle strobe, then scramble so stale data never looks valid
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge MCLK);
    #1;
    CFG_ADDR  = addr;
    CFG_WDATA = data;
    CFG_WR    = wr;
    CFG_RD    = ~wr;
    @(posedge MCLK);
    #1;
    CFG_WR    = 1'b0;
    CFG_RD    = 1'b0;
    CFG_WDATA = ~data;
    CFG_ADDR  = ~addr;
  endtask
endmodule // hpbsc_cfg_host
`default_nettype wire

// File: sim/test_hub_phy_boost_and_swap_config.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Boost and swap bench
// ****************************************
module test_hub_phy_boost_and_swap_config;
  logic                    mclk, rst_n, wr, rd, rvalid;
  logic [7:0]              addr, wdata, rdata;
  hpbsc_pkg::hpbsc_boost_t up, d1, d2;
  hpbsc_pkg::hpbsc_ports_t swp, cpo, cno, coe, cpi, cni, ppi, npi, ppo, npo, ppoe, npoe;
  logic [7:0]              exp_q[$];
  int                      failures = 0;
  int                      cmp_count = 0;

  hpbsc_cfg_host i_hpbsc_cfg_host (.MCLK(mclk), .CFG_ADDR(addr), .CFG_WDATA(wdata),
    .CFG_WR(wr), .CFG_RD(rd));
  hpbsc_top i_hpbsc_top (.MCLK(mclk), .RST_N(rst_n), .CFG_ADDR(addr), .CFG_WDATA(wdata),
    .CFG_WR(wr), .CFG_RD(rd), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
    .UPSTREAM_BOOST_LEVEL(up), .DOWN1_BOOST_LEVEL(d1), .DOWN2_BOOST_LEVEL(d2),
    .LINE_SWAP_BITS(swp), .CORE_POS_OUT(cpo), .CORE_NEG_OUT(cno), .CORE_LINE_OE(coe),
    .CORE_POS_IN(cpi), .CORE_NEG_IN(cni), .POSITIVE_LINE_PIN_I(ppi),
    .NEGATIVE_LINE_PIN_I(npi), .POSITIVE_LINE_PIN_O(ppo), .NEGATIVE_LINE_PIN_O(npo),
    .POSITIVE_LINE_PIN_OE(ppoe), .NEGATIVE_LINE_PIN_OE(npoe));

  // 125 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Compare and count
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Note the expected data, then issue the read
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_hpbsc_cfg_host.access(1'b0, a, 8'h00);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Read monitor; an unexpected pulse counts as a mismatch
  always @(posedge mclk)
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stray_read", 8'h00, 8'hff);
      else
        check("read_data", rdata, exp_q.pop_front());
    end

  // Watchdog well beyond the fewer than two hundred cycles of the tests
  initial
  begin
    #20000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    int         i;
    logic [2:0] s;
    {rst_n, cpo, cno, coe, ppi, npi} = '0;
    void'($urandom(52367));
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    // Reset state
    rd_reg(8'hf6, 8'h00);
    rd_reg(8'hf8, 8'h00);
    rd_reg(8'hfa, 8'h00);
    check("rst_levels", 8'({d2, d1, up}), 8'h00);
    check("rst_swap", 8'(swp), 8'h00);
    $display("Test reset done");
    // Upstream codes, reserved bits filled with noise
    for (i = 0; i < 4; i++)
    begin
      i_hpbsc_cfg_host.access(1'b1, 8'hf6, {6'($urandom()), 2'(i)});
      check("up_boost", 8'(up), 8'(i));
      rd_reg(8'hf6, 8'(i));
    end
    $display("Test upstream boost done");
    // Both downstream fields, all sixteen pairs
    for (i = 0; i < 16; i++)
    begin
      i_hpbsc_cfg_host.access(1'b1, 8'hf8, {4'($urandom()), 4'(i)});
      check("dn1_boost", 8'(d1), 8'(i % 4));
      check("dn2_boost", 8'(d2), 8'(i / 4));
      rd_reg(8'hf8, 8'(i));
    end
    $display("Test downstream boost done");
    // Every swap pattern with random line traffic
    for (i = 0; i < 8; i++)
    begin
      s = 3'(i);
      i_hpbsc_cfg_host.access(1'b1, 8'hfa, {5'($urandom()), s});
      check("swap_bits", 8'(swp), 8'(s));
      rd_reg(8'hfa, 8'(s));
      repeat (2)
      begin
        {cpo, cno, coe, ppi, npi} = 15'($urandom());
        @(posedge mclk);
        #1;
        check("pos_pin", 8'(ppo), 8'((s & cno) | (~s & cpo)));
        check("neg_pin", 8'(npo), 8'((s & cpo) | (~s & cno)));
        check("core_pos", 8'(cpi), 8'((s & npi) | (~s & ppi)));
        check("core_neg", 8'(cni), 8'((s & ppi) | (~s & npi)));
        check("pin_oe", 8'({ppoe, npoe}), 8'({coe, coe}));
      end
    end
    $display("Test line swap done");
    // Unmapped places: read zero, writes change nothing
    rd_reg(8'hf7, 8'h00);
    // Zeros next to live registers would show any aliasing
    i_hpbsc_cfg_host.access(1'b1, 8'hf7, 8'h00);
    i_hpbsc_cfg_host.access(1'b1, 8'hf9, 8'h00);
    check("no_side_effect", 8'({d2, d1, up}), 8'h3f);
    check("swap_kept", 8'(swp), 8'h07);
    // Reset in mid-run clears the settings again
    @(posedge mclk);
    #1 rst_n = 1'b0;
    @(posedge mclk);
    #1 rst_n = 1'b1;
    check("rerst_swap", 8'(swp), 8'h00);
    check("rerst_boost", 8'({d2, d1, up}), 8'h00);
    rd_reg(8'hf8, 8'h00);
    repeat (3) @(posedge mclk);
    check("reads_answered", 8'(exp_q.size()), 8'h00);
    $display("Test unmapped and reset done");
    report_and_stop();
  end
endmodule // test_hub_phy_boost_and_swap_config
`default_nettype wire
